//--- rtl/flash_erase_pkg.sv
/*
 * constants, carriers and command table for the block erase host
 * assumes a 10 MHz clock and a byte-wide parallel flash on plain pins
 */
// Functional notes
// - two unlocks, then setup code to command address
// - two more unlocks, then confirm as sixth write
// - confirm address lies inside target block
// - extra confirms, no unlocks, erase in parallel
// - after failure host writes reset instruction
// - unlock pair: AA at 5555, 55 at 2AAA
// - reset is single write of F0h
// - suspend is B0h anywhere, ends timeout
package flash_erase_pkg;
	// clock and pin timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int WE_LOW_NS = 45;
	localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_STAGES = 3;
	localparam int ACC_NS = 150;
	localparam int ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
		+ SYNC_STAGES;
	// shortest erase timeout, so the longest confirm gap rounds down
	localparam int ERASE_WINDOW_US = 80;
	localparam int WINDOW_CYC = ERASE_WINDOW_US * 1000 / CLK_PERIOD_NS;
	// wait after a reset that lands during an erase
	localparam int RST_WAIT_US = 5;
	localparam int RST_WAIT_CYC = (RST_WAIT_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// flash address map and command codes
	localparam int FL_AW = 19;
	localparam int BLK_W = 3;
	localparam int BLK_LSB = FL_AW - BLK_W;
	localparam logic [18:0] UNLOCK1_ADDR = 19'h05555;
	localparam logic [18:0] UNLOCK2_ADDR = 19'h02AAA;
	localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
	localparam logic [7:0] UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] CMD_SETUP = 8'h80;
	localparam logic [7:0] CMD_CONFIRM = 8'h30;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [2:0] CONFIRM_STEP = 3'h5;
	// status byte positions on the data lines
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int FAIL_BIT = 5;
	localparam int TIMER_BIT = 3;
	// software register map and fields
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_MASK = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam int CTRL_START = 0;
	localparam int CTRL_RESET = 1;
	localparam int CTRL_SUSP = 2;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_TIMER = 3;
	localparam int ST_TOGGLE = 4;
	localparam int ST_SUSP = 5;
	localparam int ST_BYTE_LSB = 8;

	// one flash bus cycle request
	typedef struct packed {
		logic write;
		logic [18:0] addr;
		logic [7:0] data;
	} bus_req_t;

	// write number step of the six-write erase instruction
	function automatic bus_req_t cmd_step(input logic [2:0] step,
		input logic [2:0] blk);
		bus_req_t r;
		r.write = 1'b1;
		r.addr = UNLOCK1_ADDR;
		r.data = UNLOCK1_DATA;
		case (step)
			3'h1, 3'h4:
			begin
				r.addr = UNLOCK2_ADDR;
				r.data = UNLOCK2_DATA;
			end
			3'h2: r.data = CMD_SETUP;
			3'h5:
			begin
				r.addr = {blk, {BLK_LSB{1'b0}}};
				r.data = CMD_CONFIRM;
			end
			default: r.data = UNLOCK1_DATA;
		endcase
		return r;
	endfunction

	// index of the lowest set bit of a block mask
	function automatic logic [2:0] low_bit(input logic [7:0] m);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 7; i >= 0; i--)
			if (m[i])
				idx = 3'(i);
		return idx;
	endfunction
endpackage

//--- rtl/flash_bus_cycle.sv
/*
 * one write or read cycle on the flash pins
 * assumes requests only while idle; data input is asynchronous
 */
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle
(
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire flash_erase_pkg::bus_req_t req_in,
	input wire logic [7:0] dq_in,
	output logic [18:0] addr_out,
	output logic [7:0] dq_out,
	output logic dq_oe_n_out,
	output logic ce_n_out,
	output logic we_n_out,
	output logic oe_n_out,
	output logic done_out,
	output logic [7:0] rdata_out
);
	import flash_erase_pkg::*;

	typedef enum logic [2:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD,
		B_READ} bus_state_t;
	bus_state_t state, next_state; // cycle phase
	logic [7:0] cnt, next_cnt; // phase length counter
	logic [18:0] next_addr;
	logic [7:0] next_dq, next_rdata;
	logic next_dq_oe_n, next_ce_n, next_we_n, next_oe_n, next_done;
	logic [7:0] s1, s2, s3; // data input synchroniser

	// three-stage synchroniser for the data lines
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s1 <= 8'h00;
			s2 <= 8'h00;
			s3 <= 8'h00;
		end
		else
		begin
			s1 <= dq_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// next phase and pin levels
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_addr = addr_out;
		next_dq = dq_out;
		next_rdata = rdata_out;
		next_dq_oe_n = dq_oe_n_out;
		next_ce_n = ce_n_out;
		next_we_n = we_n_out;
		next_oe_n = oe_n_out;
		next_done = 1'b0;
		case (state)
			B_IDLE:
				if (start_in)
				begin
					// address and chip enable settle before the strobe
					next_addr = req_in.addr;
					next_ce_n = 1'b0;
					next_cnt = 8'h00;
					if (req_in.write)
					begin
						next_dq = req_in.data;
						next_dq_oe_n = 1'b0;
						next_state = B_SETUP;
					end
					else
					begin
						next_oe_n = 1'b0;
						next_state = B_READ;
					end
				end
			B_SETUP:
			begin
				// falling strobe: the device takes the address
				next_we_n = 1'b0;
				next_cnt = 8'h01;
				next_state = B_STROBE;
			end
			B_STROBE:
				if (cnt >= 8'(WE_LOW_CYC))
				begin
					// rising strobe: the device takes the data
					next_we_n = 1'b1;
					next_state = B_HOLD;
				end
				else
					next_cnt = cnt + 8'h01;
			B_HOLD:
			begin
				// data held one cycle past the rising strobe
				next_dq_oe_n = 1'b1;
				next_ce_n = 1'b1;
				next_done = 1'b1;
				next_state = B_IDLE;
			end
			B_READ:
			begin
				if (cnt < 8'hFF)
					next_cnt = cnt + 8'h01;
				// sample once access time passed and input is stable
				if (cnt >= 8'(ACC_CYC) && s2 == s3)
				begin
					next_rdata = s3;
					next_ce_n = 1'b1;
					next_oe_n = 1'b1;
					next_done = 1'b1;
					next_state = B_IDLE;
				end
			end
			default: next_state = B_IDLE;
		endcase
	end

	// register phase and pins
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state <= B_IDLE;
			cnt <= 8'h00;
			addr_out <= 19'h00000;
			dq_out <= 8'h00;
			rdata_out <= 8'h00;
			dq_oe_n_out <= 1'b1;
			ce_n_out <= 1'b1;
			we_n_out <= 1'b1;
			oe_n_out <= 1'b1;
			done_out <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			addr_out <= next_addr;
			dq_out <= next_dq;
			rdata_out <= next_rdata;
			dq_oe_n_out <= next_dq_oe_n;
			ce_n_out <= next_ce_n;
			we_n_out <= next_we_n;
			oe_n_out <= next_oe_n;
			done_out <= next_done;
		end
	end
endmodule
`default_nettype wire

//--- rtl/flash_erase_host.sv
/*
 * host controller that runs multi-block erase on a parallel flash
 * assumes software on a simple strobe port and the flash on plain pins
 */
`timescale 1ns/1ps
`default_nettype none
module flash_erase_host
(
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic [7:0] flash_dq_in,
	output logic [18:0] flash_addr_out,
	output logic [7:0] flash_dq_out,
	output logic flash_dq_oe_n_out,
	output logic flash_ce_n_out,
	output logic flash_we_n_out,
	output logic flash_oe_n_out
);
	import flash_erase_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_SEQ, S_MORE, S_POLL, S_RECHECK,
		S_RESET, S_RWAIT, S_SUSP} host_state_t;

	logic rst_r1, rst_r2, rst_n; // reset release
	host_state_t state, next_state; // sequencer state
	logic [2:0] step, next_step; // write number in the instruction
	logic [2:0] blk, next_blk; // first block, used for polling
	logic [7:0] mask, next_mask; // blocks software wants erased
	logic [7:0] remain, next_remain; // blocks still to confirm
	logic inflight, next_inflight; // a bus cycle is running
	logic start, next_start; // bus cycle start pulse
	bus_req_t req, next_req; // bus cycle request
	logic done_f, fail_f, timer_f, toggle_f, susp_f; // status flags
	logic next_done_f, next_fail_f, next_timer_f, next_toggle_f, next_susp_f;
	logic [7:0] last_byte, next_last_byte; // last status byte read
	logic prev6, next_prev6; // toggle bit of previous read
	logic was_erasing, next_was_erasing; // erase may be running
	logic rst_pend, next_rst_pend; // software asked for reset
	logic susp_pend, next_susp_pend; // software asked for suspend
	logic [7:0] wcnt, next_wcnt; // wait after reset
	logic [31:0] next_rdata;
	logic cyc_done; // bus cycle finished
	logic [7:0] cyc_rdata; // byte read by the bus cycle
	logic issue; // free to launch a cycle
	logic ctrl_wr; // write to the control register
	logic [15:0] gap_cnt; // cycles since last confirm strobe

	// two-flop release of the asynchronous reset
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rst_r1 <= 1'b0;
			rst_r2 <= 1'b0;
		end
		else
		begin
			rst_r1 <= 1'b1;
			rst_r2 <= rst_r1;
		end
	end
	assign rst_n = rst_r2;

	// pin sequencing for one write or read
	flash_bus_cycle u_cycle (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n),
		.start_in(start),
		.req_in(req),
		.dq_in(flash_dq_in),
		.addr_out(flash_addr_out),
		.dq_out(flash_dq_out),
		.dq_oe_n_out(flash_dq_oe_n_out),
		.ce_n_out(flash_ce_n_out),
		.we_n_out(flash_we_n_out),
		.oe_n_out(flash_oe_n_out),
		.done_out(cyc_done),
		.rdata_out(cyc_rdata)
	);

	assign issue = !inflight && !start;
	assign ctrl_wr = reg_wr_in && reg_addr_in == REG_CTRL;

	// sequencer next state
	always_comb
	begin
		next_state = state;
		next_step = step;
		next_blk = blk;
		next_mask = mask;
		next_remain = remain;
		next_inflight = inflight;
		next_start = 1'b0;
		next_req = req;
		next_done_f = done_f;
		next_fail_f = fail_f;
		next_timer_f = timer_f;
		next_toggle_f = toggle_f;
		next_susp_f = susp_f;
		next_last_byte = last_byte;
		next_prev6 = prev6;
		next_was_erasing = was_erasing;
		next_rst_pend = rst_pend;
		next_susp_pend = susp_pend;
		next_wcnt = wcnt;
		if (reg_wr_in && reg_addr_in == REG_MASK)
			next_mask = reg_wdata_in[7:0];
		if (cyc_done)
			next_inflight = 1'b0;
		case (state)
			S_IDLE:
				if (rst_pend)
				begin
					next_rst_pend = 1'b0;
					next_state = S_RESET;
				end
				else if (ctrl_wr && reg_wdata_in[CTRL_START] && mask != 8'h00)
				begin
					// latch the block set and open the instruction
					next_remain = mask;
					next_blk = low_bit(mask);
					next_step = 3'h0;
					next_done_f = 1'b0;
					next_fail_f = 1'b0;
					next_timer_f = 1'b0;
					next_susp_f = 1'b0;
					next_susp_pend = 1'b0;
					next_state = S_SEQ;
				end
			S_SEQ:
			begin
				// unlock, setup, unlock, first confirm
				if (issue)
				begin
					next_start = 1'b1;
					next_inflight = 1'b1;
					next_req = cmd_step(step, blk);
				end
				if (cyc_done)
				begin
					if (step == CONFIRM_STEP)
					begin
						next_remain[blk] = 1'b0;
						next_state = S_MORE;
					end
					else
						next_step = step + 3'h1;
				end
			end
			S_MORE:
				// further confirms follow back to back, no unlocks
				if (remain == 8'h00 && issue)
				begin
					next_was_erasing = 1'b1;
					next_state = S_POLL;
				end
				else if (remain != 8'h00)
				begin
					if (issue)
					begin
						next_start = 1'b1;
						next_inflight = 1'b1;
						next_req = cmd_step(CONFIRM_STEP, low_bit(remain));
					end
					if (cyc_done)
						next_remain[low_bit(remain)] = 1'b0;
				end
			S_POLL, S_RECHECK:
				if (issue && rst_pend)
				begin
					// only reset or suspend may interrupt the erase
					next_rst_pend = 1'b0;
					next_state = S_RESET;
				end
				else if (issue && susp_pend && state == S_POLL)
				begin
					next_susp_pend = 1'b0;
					next_state = S_SUSP;
				end
				else
				begin
					if (issue)
					begin
						next_start = 1'b1;
						next_inflight = 1'b1;
						next_req.write = 1'b0;
						next_req.addr = {blk, {BLK_LSB{1'b0}}};
					end
					if (cyc_done)
					begin
						next_last_byte = cyc_rdata;
						next_timer_f = cyc_rdata[TIMER_BIT];
						next_toggle_f = cyc_rdata[TOGGLE_BIT] ^ prev6;
						next_prev6 = cyc_rdata[TOGGLE_BIT];
						if (cyc_rdata[POLL_BIT])
						begin
							// polling bit high: erase complete
							next_done_f = 1'b1;
							next_was_erasing = 1'b0;
							next_state = S_IDLE;
						end
						else if (state == S_RECHECK)
						begin
							// failure confirmed by a second read
							next_fail_f = 1'b1;
							next_state = S_RESET;
						end
						else if (cyc_rdata[FAIL_BIT])
							next_state = S_RECHECK;
					end
				end
			S_RESET:
			begin
				if (issue)
				begin
					next_start = 1'b1;
					next_inflight = 1'b1;
					next_req.write = 1'b1;
					next_req.addr = UNLOCK1_ADDR;
					next_req.data = CMD_RESET;
				end
				if (cyc_done)
				begin
					next_wcnt = 8'h00;
					next_was_erasing = 1'b0;
					next_susp_f = 1'b0;
					next_state = was_erasing ? S_RWAIT : S_IDLE;
				end
			end
			S_RWAIT:
			begin
				// the device needs time after a reset mid-erase
				next_wcnt = wcnt + 8'h01;
				if (wcnt >= 8'(RST_WAIT_CYC - 1))
					next_state = S_IDLE;
			end
			S_SUSP:
			begin
				if (issue)
				begin
					next_start = 1'b1;
					next_inflight = 1'b1;
					next_req.write = 1'b1;
					next_req.data = CMD_SUSPEND;
				end
				if (cyc_done)
				begin
					next_susp_f = 1'b1;
					next_state = S_IDLE;
				end
			end
			default: next_state = S_IDLE;
		endcase
		// a request arriving with its own clear is kept
		if (ctrl_wr && reg_wdata_in[CTRL_RESET])
			next_rst_pend = 1'b1;
		if (ctrl_wr && reg_wdata_in[CTRL_SUSP])
			next_susp_pend = 1'b1;
	end

	// read data for the software port, valid the cycle after
	always_comb
	begin
		next_rdata = 32'h00000000;
		if (reg_rd_in)
		begin
			if (reg_addr_in == REG_MASK)
				next_rdata[7:0] = mask;
			else if (reg_addr_in == REG_STATUS)
			begin
				next_rdata[ST_BUSY] = state != S_IDLE;
				next_rdata[ST_DONE] = done_f;
				next_rdata[ST_FAIL] = fail_f;
				next_rdata[ST_TIMER] = timer_f;
				next_rdata[ST_TOGGLE] = toggle_f;
				next_rdata[ST_SUSP] = susp_f;
				next_rdata[ST_BYTE_LSB +: 8] = last_byte;
			end
		end
	end

	// register sequencer state
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= S_IDLE;
			step <= 3'h0;
			blk <= 3'h0;
			mask <= 8'h00;
			remain <= 8'h00;
			inflight <= 1'b0;
			start <= 1'b0;
			req <= '0;
			{done_f, fail_f, timer_f, toggle_f, susp_f} <= 5'h00;
			last_byte <= 8'h00;
			prev6 <= 1'b0;
			was_erasing <= 1'b0;
			rst_pend <= 1'b0;
			susp_pend <= 1'b0;
			wcnt <= 8'h00;
			reg_rdata_out <= 32'h00000000;
		end
		else
		begin
			state <= next_state;
			step <= next_step;
			blk <= next_blk;
			mask <= next_mask;
			remain <= next_remain;
			inflight <= next_inflight;
			start <= next_start;
			req <= next_req;
			done_f <= next_done_f;
			fail_f <= next_fail_f;
			timer_f <= next_timer_f;
			toggle_f <= next_toggle_f;
			susp_f <= next_susp_f;
			last_byte <= next_last_byte;
			prev6 <= next_prev6;
			was_erasing <= next_was_erasing;
			rst_pend <= next_rst_pend;
			susp_pend <= next_susp_pend;
			wcnt <= next_wcnt;
			reg_rdata_out <= next_rdata;
		end
	end

	// helper: cycles since the last confirm strobe while confirming
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			gap_cnt <= 16'h0000;
		else if (state != S_MORE || $fell(flash_we_n_out))
			gap_cnt <= 16'h0000;
		else
			gap_cnt <= gap_cnt + 16'h0001;
	end

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n);

	a_unlock_first: assert property ($fell(flash_we_n_out) && state == S_SEQ
		&& (step == 3'h0 || step == 3'h3) |-> flash_addr_out == UNLOCK1_ADDR
		&& flash_dq_out == UNLOCK1_DATA) else $error("bad first unlock write");
	a_unlock_second: assert property ($fell(flash_we_n_out) && state == S_SEQ
		&& (step == 3'h1 || step == 3'h4) |-> flash_addr_out == UNLOCK2_ADDR
		&& flash_dq_out == UNLOCK2_DATA) else $error("bad second unlock write");
	a_setup_cmd: assert property ($fell(flash_we_n_out) && state == S_SEQ
		&& step == 3'h2 |-> flash_addr_out == UNLOCK1_ADDR
		&& flash_dq_out == CMD_SETUP) else $error("bad setup write");
	a_confirm_cmd: assert property ($fell(flash_we_n_out) && state == S_SEQ
		&& step == CONFIRM_STEP |-> flash_dq_out == CMD_CONFIRM
		&& flash_addr_out[FL_AW-1:BLK_LSB] == blk) else $error("bad confirm");
	a_extra_confirm: assert property ($fell(flash_we_n_out) && state == S_MORE
		|-> flash_dq_out == CMD_CONFIRM && remain[flash_addr_out[FL_AW-1:BLK_LSB]])
		else $error("extra confirm wrong code or block");
	a_confirm_gap: assert property (gap_cnt < 16'(WINDOW_CYC))
		else $error("confirm gap exceeds erase timeout");
	a_fail_reset: assert property (state == S_RECHECK && cyc_done
		&& !cyc_rdata[POLL_BIT] |-> ##[1:20] ($fell(flash_we_n_out)
		&& flash_dq_out == CMD_RESET)) else $error("no reset after failure");
	a_reset_code: assert property ($fell(flash_we_n_out) && state == S_RESET
		|-> flash_dq_out == CMD_RESET && $past(state) == S_RESET)
		else $error("reset write not F0");
	a_suspend_code: assert property ($fell(flash_we_n_out) && state == S_SUSP
		|-> flash_dq_out == CMD_SUSPEND) else $error("suspend write not B0");

	c_erase_done: cover property (state == S_POLL ##1 state == S_IDLE && done_f);
	c_multi_block: cover property ($fell(flash_we_n_out) && state == S_MORE);
	c_erase_fail: cover property (state == S_RECHECK ##1 state == S_RESET);
	c_suspend: cover property (state == S_SUSP ##1 state == S_IDLE);
endmodule
`default_nettype wire

//--- verif/flash_dev_model.sv
/*
 * behavioural byte-wide flash: block erase command interface and status
 * assumes the host drives ce, we and oe and releases dq between cycles
 */
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
#(
	parameter int TMO_NS = 100000,
	parameter int ERASE_NS = 200000
)
(
	input wire logic ce_n_in,
	input wire logic we_n_in,
	input wire logic oe_n_in,
	input wire logic [18:0] addr_in,
	input wire logic [7:0] dq_in,
	input wire logic fail_mode_in,
	output logic [7:0] dq_out
);
	import flash_erase_pkg::*;
	// command interface modes
	localparam int M_READ = 0;
	localparam int M_TMO = 1;
	localparam int M_ERASE = 2;
	localparam int M_SUSP = 3;
	int mode = M_READ;
	int step = 0; // position in the six-write sequence
	int seq_err = 0;
	int rst_cnt = 0;
	int susp_cnt = 0;
	int conf_cnt = 0;
	int wr_cnt = 0;
	logic [7:0] blocks = 8'h00; // blocks chosen for erase
	logic [18:0] lat_a = 19'h00000;
	logic [7:0] drv;
	logic [7:0] last = 8'h00;
	logic tog = 1'b0;
	logic failed = 1'b0;
	logic ok;
	time t0 = 0;
	// address taken as write enable falls
	always @(negedge we_n_in)
		if (!ce_n_in)
			lat_a = addr_in;
	// command decode as write enable rises, data taken here
	always @(posedge we_n_in)
	begin
		if (!ce_n_in)
		begin
			wr_cnt++;
			if (dq_in == CMD_RESET)
			begin
				mode = M_READ;
				step = 0;
				failed = 1'b0;
				rst_cnt++;
			end
			else if (dq_in == CMD_SUSPEND && (mode == M_TMO || mode == M_ERASE))
			begin
				mode = M_SUSP;
				susp_cnt++;
			end
			else if (mode == M_TMO)
			begin
				if (dq_in == CMD_CONFIRM)
				begin
					blocks[lat_a[18:16]] = 1'b1;
					conf_cnt++;
					t0 = $time;
				end
				else
					mode = M_READ;
			end
			else if (mode == M_READ)
			begin
				case (step)
					0, 3: ok = lat_a == UNLOCK1_ADDR && dq_in == UNLOCK1_DATA;
					1, 4: ok = lat_a == UNLOCK2_ADDR && dq_in == UNLOCK2_DATA;
					2: ok = lat_a == UNLOCK1_ADDR && dq_in == CMD_SETUP;
					default: ok = dq_in == CMD_CONFIRM;
				endcase
				if (!ok)
				begin
					seq_err++;
					step = 0;
				end
				else if (step == 5)
				begin
					blocks = 8'h00;
					blocks[lat_a[18:16]] = 1'b1;
					conf_cnt = 1;
					t0 = $time;
					mode = M_TMO;
					step = 0;
				end
				else
					step++;
			end
			// while erasing anything else is ignored
		end
	end
	// erase timeout, then erase run or failure
	always #100
	begin
		if (mode == M_TMO && $time - t0 >= TMO_NS)
		begin
			mode = M_ERASE;
			t0 = $time;
		end
		else if (mode == M_ERASE && $time - t0 >= ERASE_NS)
		begin
			if (fail_mode_in)
				failed = 1'b1;
			else
				mode = M_READ;
		end
	end
	// toggle bit flips on each read while busy
	always @(negedge oe_n_in)
		if (!ce_n_in && (mode == M_TMO || mode == M_ERASE))
			tog = ~tog;
	// status while busy, erased ones or a pattern otherwise
	always @*
	begin
		if (mode == M_TMO || mode == M_ERASE)
			drv = {1'b0, tog, failed, 1'b0, mode == M_ERASE, 3'b000};
		else if (mode == M_READ && blocks[addr_in[18:16]])
			drv = 8'hFF;
		else
			drv = addr_in[7:0] ^ 8'h5A;
	end
	always @(posedge oe_n_in)
		last = drv;
	// released bus shows the inverse of the last byte
	assign dq_out = (!ce_n_in && !oe_n_in) ? drv : ~last;
endmodule
`default_nettype wire

//--- verif/flash_erase_host_tb.sv
/*
 * self-checking bench for the block erase host
 * assumes the flash model beside it and a 10 MHz clock
 */
`timescale 1ns/1ps
`default_nettype none
module flash_erase_host_tb;
	import flash_erase_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_d = 1'b0;
	logic fail_mode = 1'b0;
	wire logic [31:0] reg_rdata;
	wire logic [7:0] host_dq;
	wire logic [7:0] dev_dq;
	wire logic [7:0] dq_bus;
	wire logic [18:0] fl_addr;
	wire logic dq_oe_n;
	wire logic ce_n;
	wire logic we_n;
	wire logic oe_n;
	int err_total = 0;
	int comparisons = 0;
	logic [31:0] exp_q[$]; // expected read words
	logic [31:0] msk_q[$]; // bits that matter, zero for polls
	logic [31:0] mon_e;
	logic [31:0] mon_m;
	logic [31:0] v;
	logic [7:0] m8;
	// host wins the data lines while it drives them
	assign dq_bus = dq_oe_n ? dev_dq : host_dq;
	initial forever #50 clk = ~clk;
	flash_erase_host u_dut (.ref_clk_in(clk), .resetn_in(resetn),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .flash_dq_in(dq_bus),
		.flash_addr_out(fl_addr), .flash_dq_out(host_dq),
		.flash_dq_oe_n_out(dq_oe_n), .flash_ce_n_out(ce_n),
		.flash_we_n_out(we_n), .flash_oe_n_out(oe_n));
	flash_dev_model u_dev (.ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n),
		.addr_in(fl_addr), .dq_in(dq_bus), .fail_mode_in(fail_mode),
		.dq_out(dev_dq));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (err_total == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read: the expectation is noted, the monitor compares
	task automatic rd(input logic [3:0] a, input logic [31:0] e,
		input logic [31:0] m, output logic [31:0] r);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		r = reg_rdata;
	endtask
	// poll status until the controller leaves busy, bounded
	task automatic wait_idle();
		logic [31:0] s;
		int n;
		s = 32'h1;
		n = 0;
		while (s[ST_BUSY] !== 1'b0 && n < 2000)
		begin
			rd(REG_STATUS, 32'h0, 32'h0, s);
			n++;
		end
		if (n >= 2000)
			err_total++;
	endtask
	// read data stand only in the cycle after the strobe
	always @(posedge clk)
		rd_d <= reg_rd;
	// compare on the falling edge, once the read data have settled
	always @(negedge clk)
	begin
		if (rd_d && exp_q.size() > 0)
		begin
			mon_e = exp_q.pop_front();
			mon_m = msk_q.pop_front();
			if (mon_m != 32'h0)
				check(reg_rdata & mon_m, mon_e & mon_m);
		end
	end
	// watchdog against a hang
	initial
	begin
		repeat (40000) @(posedge clk);
		err_total++;
		print_verdict();
	end
	initial
	begin
		void'($urandom(32'h7BB9A3CF));
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (5) @(posedge clk);
		// reset values and an unmapped address
		rd(REG_CTRL, 32'h0, 32'hFFFFFFFF, v);
		rd(REG_MASK, 32'h0, 32'hFFFFFFFF, v);
		rd(REG_STATUS, 32'h0, 32'hFFFFFFFF, v);
		rd(4'hC, 32'h0, 32'hFFFFFFFF, v);
		// start with no block chosen must not touch the flash
		wr(REG_CTRL, 32'h1);
		repeat (50) @(posedge clk);
		check(32'(u_dev.wr_cnt), 32'h0);
		// reset request while idle: a single write, no wait
		wr(REG_CTRL, 32'h2);
		repeat (20) @(posedge clk);
		check(32'(u_dev.rst_cnt), 32'h1);
		// random blocks, both edge blocks forced in
		m8 = 8'($urandom) | 8'h81;
		wr(REG_MASK, {24'h0, m8});
		rd(REG_MASK, {24'h0, m8}, 32'hFF, v);
		// full erase: timer phase, busy phase, completion
		wr(REG_CTRL, 32'h1);
		repeat (300) @(posedge clk);
		rd(REG_STATUS, 32'h1, 32'h8009, v);
		repeat (1000) @(posedge clk);
		rd(REG_STATUS, 32'h19, 32'h8019, v);
		wait_idle();
		rd(REG_STATUS, 32'hFF0A, 32'hFF0F, v);
		check(32'(u_dev.blocks), {24'h0, m8});
		check(32'(u_dev.conf_cnt), 32'($countones(m8)));
		check(32'(u_dev.seq_err), 32'h0);
		// reset in mid-erase, nothing else written meanwhile
		wr(REG_CTRL, 32'h1);
		repeat (1300) @(posedge clk);
		wr(REG_CTRL, 32'h2);
		wait_idle();
		check(32'(u_dev.rst_cnt), 32'h2);
		check(32'(u_dev.mode), 32'h0);
		check(32'(u_dev.wr_cnt), 32'(2 * (5 + $countones(m8)) + 2));
		// erase that never verifies
		fail_mode <= 1'b1;
		wr(REG_CTRL, 32'h1);
		repeat (20) @(posedge clk);
		wait_idle();
		rd(REG_STATUS, 32'h4, 32'h5, v);
		check(32'(u_dev.rst_cnt), 32'h3);
		fail_mode <= 1'b0;
		// suspend during the erase
		wr(REG_CTRL, 32'h1);
		repeat (1300) @(posedge clk);
		wr(REG_CTRL, 32'h4);
		repeat (100) @(posedge clk);
		rd(REG_STATUS, 32'h20, 32'h20, v);
		check(32'(u_dev.susp_cnt), 32'h1);
		repeat (5) @(posedge clk);
		print_verdict();
	end
endmodule
`default_nettype wire
